/* core/cdhp_host_port.sv */
// Design decisions made here: the address-and-strobe port and the register addresses.
module cdhp_host_port (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [1:0] mode_sel,
  input  wire logic       ext_reset_en,
  input  wire logic       reset_pin_n,
  input  wire logic       register_select_line,
  input  wire logic       rw_line,
  input  wire logic       enable_strobe,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] data_lines_in,
  output logic      [7:0] data_lines_out,
  output logic            data_lines_oe_n,
  input  wire logic       serial_clk,
  input  wire logic       frame_select,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_data_oe_n,
  input  wire logic       disp_row,
  input  wire logic [4:0] disp_col,
  input  wire logic [2:0] glyph_row,
  output logic      [7:0] disp_code,
  output logic      [7:0] glyph_bits,
  output logic            glyph_hit,
  output logic      [6:0] address_counter,
  output logic            bus_width_bit
);
  typedef struct packed {
    logic [16:0] p1;
    logic [16:0] p2;
    logic [16:0] pd;
    logic [6:0]  ac;
    logic        glyph_sel;
    logic        inc;
    logic        shift_en;
    logic        dl;
    logic [5:0]  offset;
    logic        nib_hi;
    logic [3:0]  nib_buf;
    logic        drive;
    logic [7:0]  dout;
    logic [7:0]  disp_code;
    logic [7:0]  glyph_bits;
    logic        glyph_hit;
  } cdhp_core_t;

  localparam cdhp_core_t RST_STATE = '{
    p1: cdhp_pkg::PIN_IDLE, p2: cdhp_pkg::PIN_IDLE, pd: cdhp_pkg::PIN_IDLE,
    ac: cdhp_pkg::RST_AC, offset: cdhp_pkg::RST_OFFSET, inc: cdhp_pkg::RST_INC,
    shift_en: cdhp_pkg::RST_SHIFT_EN, dl: cdhp_pkg::RST_BUS_WIDTH, nib_hi: cdhp_pkg::RST_NIB_HI,
    default: '0};

  cdhp_core_t st;
  cdhp_core_t n;
  cdhp_ser_if ser ();

  logic [7:0] dmem [0:127];
  logic [7:0] gmem [0:63];

  ////////////////////////////////////////////////////////////////////////////////
  // counter and shift stepping

  function automatic logic [6:0] ac_next(input logic [6:0] a, input logic g, input logic up);
    logic [5:0] c;
    c = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
    if (g) begin
      return {1'b0, c};
    end
    if (up) begin
      return (a == cdhp_pkg::DD_ROW1_LAST) ? cdhp_pkg::DD_ROW2_FIRST :
             (a == cdhp_pkg::DD_ROW2_LAST) ? cdhp_pkg::DD_FIRST : a + 7'h01;
    end
    return (a == cdhp_pkg::DD_ROW2_FIRST) ? cdhp_pkg::DD_ROW1_LAST :
           (a == cdhp_pkg::DD_FIRST) ? cdhp_pkg::DD_ROW2_LAST : a - 7'h01;
  endfunction : ac_next

  function automatic logic [5:0] off_next(input logic [5:0] o, input logic left);
    if (left) begin
      return (o == cdhp_pkg::OFF_LAST) ? 6'h00 : o + 6'h01;
    end
    return (o == 6'h00) ? cdhp_pkg::OFF_LAST : o - 6'h01;
  endfunction : off_next

  ////////////////////////////////////////////////////////////////////////////////
  // synchronised pins and edges

  logic [1:0] mode;
  logic       par_mode;
  logic       int_rst;
  logic       rs_s;
  logic       rw_s;
  logic [7:0] d_s;
  logic       e_rise;
  logic       e_fall;
  logic       wr_rise;
  logic       rd_fall;
  logic       rd_rise;
  logic       wr_ev;
  logic       rd_start;
  logic       rd_end;

  assign mode     = st.p2[cdhp_pkg::PIN_MODE +: 2];
  assign par_mode = (mode != cdhp_pkg::MODE_SERIAL);
  assign int_rst  = par_mode & st.p2[cdhp_pkg::PIN_EXT] & ~st.p2[cdhp_pkg::PIN_RSTN];
  assign rs_s     = st.p2[cdhp_pkg::PIN_RS];
  assign rw_s     = st.p2[cdhp_pkg::PIN_RW];
  assign d_s      = st.p2[7:0];
  assign e_rise   = st.p2[cdhp_pkg::PIN_E] & ~st.pd[cdhp_pkg::PIN_E];
  assign e_fall   = ~st.p2[cdhp_pkg::PIN_E] & st.pd[cdhp_pkg::PIN_E];
  assign wr_rise  = st.p2[cdhp_pkg::PIN_WR_N] & ~st.pd[cdhp_pkg::PIN_WR_N];
  assign rd_fall  = ~st.p2[cdhp_pkg::PIN_RD_N] & st.pd[cdhp_pkg::PIN_RD_N];
  assign rd_rise  = st.p2[cdhp_pkg::PIN_RD_N] & ~st.pd[cdhp_pkg::PIN_RD_N];

  always_comb begin
    wr_ev = 1'b0;
    rd_start = 1'b0;
    rd_end = 1'b0;
    case (mode)
      cdhp_pkg::MODE_STROBE: begin
        wr_ev = e_fall & ~rw_s;
        rd_start = e_rise & rw_s;
        rd_end = e_fall & rw_s;
      end
      cdhp_pkg::MODE_RDWR: begin
        wr_ev = wr_rise;
        rd_start = rd_fall;
        rd_end = rd_rise;
      end
      default: begin
        wr_ev = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // access decode shared by parallel and serial paths

  logic       byte_done;
  logic [7:0] par_byte;
  logic       wr_acc;
  logic       wr_rs;
  logic [7:0] wr_byte;
  logic       rd_acc;
  logic [7:0] mem_q;
  logic [7:0] par_rd;
  logic       dd_valid;
  logic       mem_we;
  logic [6:0] disp_addr;
  logic [6:0] col_sum;
  logic [5:0] glyph_addr;

  assign byte_done = st.dl | ~st.nib_hi;
  assign par_byte  = st.dl ? d_s : {st.nib_buf, d_s[7:4]};
  assign wr_acc    = (wr_ev & byte_done) | ser.wr_done;
  assign wr_rs     = ser.wr_done ? ser.sel_data : rs_s;
  assign wr_byte   = ser.wr_done ? ser.wr_byte : par_byte;
  assign rd_acc    = (rd_end & byte_done & rs_s) | (ser.rd_done & ser.sel_data);
  assign dd_valid  = (st.ac <= cdhp_pkg::DD_ROW1_LAST) ||
                     (st.ac >= cdhp_pkg::DD_ROW2_FIRST && st.ac <= cdhp_pkg::DD_ROW2_LAST);
  assign mem_q     = st.glyph_sel ? gmem[st.ac[5:0]] : (dd_valid ? dmem[st.ac] : 8'h00);
  assign par_rd    = rs_s ? mem_q : {1'b0, st.ac};
  assign ser.rd_byte = ser.sel_data ? mem_q : {1'b0, st.ac};
  assign mem_we    = wr_acc & wr_rs & ~int_rst & (st.glyph_sel | dd_valid);

  assign col_sum    = 7'({2'b00, disp_col} + {1'b0, st.offset});
  assign disp_addr  = {disp_row, (col_sum >= cdhp_pkg::OFF_SPAN) ? 6'(col_sum - cdhp_pkg::OFF_SPAN) : col_sum[5:0]};
  assign glyph_addr = {st.disp_code[2:0], glyph_row};

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = st;
    n.p1 = {mode_sel, ext_reset_en, reset_pin_n, enable_strobe, rw_line, register_select_line,
            write_strobe_n, read_strobe_n, data_lines_in};
    n.p2 = st.p1;
    n.pd = st.p2;
    if (~st.dl && (wr_ev || rd_end)) begin
      n.nib_hi = ~st.nib_hi;
    end
    if (wr_ev && ~st.dl && st.nib_hi) begin
      n.nib_buf = d_s[7:4];
    end
    if (rd_start) begin
      n.drive = 1'b1;
      n.dout = st.dl ? par_rd : (st.nib_hi ? {par_rd[7:4], 4'h0} : {par_rd[3:0], 4'h0});
    end
    if (rd_end) begin
      n.drive = 1'b0;
    end
    if ((wr_acc && wr_rs) || rd_acc) begin
      n.ac = ac_next(st.ac, st.glyph_sel, st.inc);
    end
    if (wr_acc && wr_rs && !st.glyph_sel && st.shift_en) begin
      n.offset = off_next(st.offset, st.inc);
    end
    if (wr_acc && !wr_rs) begin
      casez (wr_byte)
        8'b1???????: begin
          n.ac = wr_byte[6:0];
          n.glyph_sel = 1'b0;
        end
        8'b01??????: begin
          n.ac = {1'b0, wr_byte[5:0]};
          n.glyph_sel = 1'b1;
        end
        8'b001?????: begin
          n.dl = wr_byte[cdhp_pkg::FS_DL_BIT];
          n.nib_hi = 1'b1;
        end
        8'b0001????: begin
          n.ac = ac_next(st.ac, 1'b0, wr_byte[cdhp_pkg::SH_RL_BIT]);
          n.glyph_sel = 1'b0;
          if (wr_byte[cdhp_pkg::SH_SC_BIT]) begin
            n.offset = off_next(st.offset, ~wr_byte[cdhp_pkg::SH_RL_BIT]);
          end
        end
        8'b000001??: begin
          n.inc = wr_byte[cdhp_pkg::EM_ID_BIT];
          n.shift_en = wr_byte[cdhp_pkg::EM_S_BIT];
        end
        8'b0000001?: begin
          n.ac = cdhp_pkg::RST_AC;
          n.offset = cdhp_pkg::RST_OFFSET;
          n.glyph_sel = 1'b0;
        end
        8'b00000001: begin
          n.ac = cdhp_pkg::RST_AC;
          n.offset = cdhp_pkg::RST_OFFSET;
          n.glyph_sel = 1'b0;
          n.inc = 1'b1;
        end
        default: begin
          n.glyph_sel = st.glyph_sel;
        end
      endcase
    end
    n.disp_code = dmem[disp_addr];
    n.glyph_hit = (st.disp_code <= cdhp_pkg::GLYPH_CODE_MAX);
    n.glyph_bits = gmem[glyph_addr];
    if (int_rst) begin
      n.ac = cdhp_pkg::RST_AC;
      n.offset = cdhp_pkg::RST_OFFSET;
      n.glyph_sel = 1'b0;
      n.inc = cdhp_pkg::RST_INC;
      n.shift_en = cdhp_pkg::RST_SHIFT_EN;
      n.dl = cdhp_pkg::RST_BUS_WIDTH;
      n.nib_hi = cdhp_pkg::RST_NIB_HI;
      n.drive = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= RST_STATE;
    end else begin
      st <= n;
    end
  end

  // memories keep contents through reset
  always_ff @(posedge ref_clk) begin
    if (!rst && mem_we) begin
      if (st.glyph_sel) begin
        gmem[st.ac[5:0]] <= wr_byte;
      end else begin
        dmem[st.ac] <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial link and outputs

  cdhp_serial_link u_serial (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .ser_en           (~par_mode),
    .serial_clk       (serial_clk),
    .frame_select     (frame_select),
    .serial_data_in   (serial_data_in),
    .serial_data_out  (serial_data_out),
    .serial_data_oe_n (serial_data_oe_n),
    .ser              (ser.link)
  );

  assign data_lines_out  = st.dout;
  assign data_lines_oe_n = ~st.drive;
  assign disp_code       = st.disp_code;
  assign glyph_bits      = st.glyph_bits;
  assign glyph_hit       = st.glyph_hit;
  assign address_counter = st.ac;
  assign bus_width_bit   = st.dl;

  a_dd_inc_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (((wr_acc && wr_rs) || rd_acc) && !int_rst && !st.glyph_sel && st.inc && st.ac == 7'h27) |=> st.ac == 7'h40)
    else $error("display counter did not wrap 27h to 40h");
  a_dd_dec_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (((wr_acc && wr_rs) || rd_acc) && !int_rst && !st.glyph_sel && !st.inc && st.ac == 7'h00) |=> st.ac == 7'h67)
    else $error("display counter did not wrap 00h to 67h");
  a_glyph_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (((wr_acc && wr_rs) || rd_acc) && !int_rst && st.glyph_sel && st.inc && st.ac == 7'h3f) |=> st.ac == 7'h00)
    else $error("glyph counter did not wrap 3fh to 00h");
  a_read_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_start && !int_rst) |=> (!data_lines_oe_n && data_lines_out == ($past(st.dl) ? $past(par_rd) :
      {($past(st.nib_hi) ? $past(par_rd[7:4]) : $past(par_rd[3:0])), 4'h0})))
    else $error("read data not driven after read strobe");
  a_nibble_toggle: assert property (@(posedge ref_clk) disable iff (rst)
    (!st.dl && wr_ev && !int_rst && !(wr_acc && !wr_rs)) |=> st.nib_hi != $past(st.nib_hi))
    else $error("nibble phase did not toggle on accepted nibble");
  a_shift_right_map: assert property (@(posedge ref_clk) disable iff (rst)
    (st.offset == 6'h27 && disp_col == 5'h00 && disp_row) |-> disp_addr == 7'h67)
    else $error("right shifted first column does not show 67h");
  a_ext_reset: assert property (@(posedge ref_clk) disable iff (rst)
    int_rst |=> (st.ac == 7'h00 && data_lines_oe_n && st.nib_hi))
    else $error("external reset did not clear port state");
endmodule : cdhp_host_port

/* core/cdhp_pkg.sv */
package cdhp_pkg;
  localparam logic [1:0] MODE_STROBE = 2'h0;
  localparam logic [1:0] MODE_RDWR   = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;

  localparam logic [6:0] DD_FIRST     = 7'h00;
  localparam logic [6:0] DD_ROW1_LAST = 7'h27;
  localparam logic [6:0] DD_ROW2_FIRST = 7'h40;
  localparam logic [6:0] DD_ROW2_LAST = 7'h67;
  localparam logic [5:0] OFF_LAST     = 6'h27;
  localparam logic [6:0] OFF_SPAN     = 7'h28;
  localparam logic [7:0] GLYPH_CODE_MAX = 8'h0f;

  localparam int FS_DL_BIT = 4;
  localparam int SH_SC_BIT = 3;
  localparam int SH_RL_BIT = 2;
  localparam int EM_ID_BIT = 1;
  localparam int EM_S_BIT  = 0;

  localparam int PIN_RD_N  = 8;
  localparam int PIN_WR_N  = 9;
  localparam int PIN_RS    = 10;
  localparam int PIN_RW    = 11;
  localparam int PIN_E     = 12;
  localparam int PIN_RSTN  = 13;
  localparam int PIN_EXT   = 14;
  localparam int PIN_MODE  = 15;
  localparam logic [16:0] PIN_IDLE = 17'h02300;

  localparam int SER_SCK = 2;
  localparam int SER_FS  = 1;
  localparam int SER_SI  = 0;
  localparam logic [2:0] SER_IDLE = 3'h6;
  localparam logic [4:0] HDR_RW_POS   = 5'h05;
  localparam logic [4:0] HDR_RS_POS   = 5'h06;
  localparam logic [4:0] HDR_BITS     = 5'h08;
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [3:0] OUT_BITS     = 4'h8;

  localparam logic [6:0] RST_AC       = 7'h00;
  localparam logic [5:0] RST_OFFSET   = 6'h00;
  localparam logic       RST_INC      = 1'b1;
  localparam logic       RST_SHIFT_EN = 1'b0;
  localparam logic       RST_BUS_WIDTH = 1'b1;
  localparam logic       RST_NIB_HI   = 1'b1;
endpackage : cdhp_pkg

/* core/cdhp_ser_if.sv */
interface cdhp_ser_if;
  logic       wr_done;
  logic       rd_done;
  logic       sel_data;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  modport link (output wr_done, output rd_done, output sel_data, output wr_byte, input rd_byte);
  modport core (input wr_done, input rd_done, input sel_data, input wr_byte, output rd_byte);
endinterface : cdhp_ser_if

/* core/cdhp_serial_link.sv */
module cdhp_serial_link (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ser_en,
  input  wire logic serial_clk,
  input  wire logic frame_select,
  input  wire logic serial_data_in,
  output logic      serial_data_out,
  output logic      serial_data_oe_n,
  cdhp_ser_if.link  ser
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] sd;
    logic       in_frame;
    logic [4:0] cnt;
    logic       is_read;
    logic       sel_data;
    logic [7:0] in_sh;
    logic [3:0] falls;
    logic [7:0] out_sh;
    logic       sio_out;
    logic       oe_n;
    logic       wr_done;
    logic       rd_done;
  } cdhp_ser_t;

  localparam cdhp_ser_t RST_STATE = '{s1: cdhp_pkg::SER_IDLE, s2: cdhp_pkg::SER_IDLE, sd: cdhp_pkg::SER_IDLE,
                                      oe_n: 1'b1, default: '0};

  cdhp_ser_t st;
  cdhp_ser_t n;
  logic      sck_rise;
  logic      sck_fall;
  logic      fs_rise;
  logic      fs_fall;
  logic      si;

  assign sck_rise = st.s2[cdhp_pkg::SER_SCK] & ~st.sd[cdhp_pkg::SER_SCK];
  assign sck_fall = ~st.s2[cdhp_pkg::SER_SCK] & st.sd[cdhp_pkg::SER_SCK];
  assign fs_rise  = st.s2[cdhp_pkg::SER_FS] & ~st.sd[cdhp_pkg::SER_FS];
  assign fs_fall  = ~st.s2[cdhp_pkg::SER_FS] & st.sd[cdhp_pkg::SER_FS];
  assign si       = st.s2[cdhp_pkg::SER_SI];

  always_comb begin
    logic [7:0] byte_v;
    byte_v = st.out_sh;
    n = st;
    n.s1 = {serial_clk, frame_select, serial_data_in};
    n.s2 = st.s1;
    n.sd = st.s2;
    n.wr_done = 1'b0;
    n.rd_done = 1'b0;
    if (!ser_en) begin
      n.in_frame = 1'b0;
      n.oe_n = 1'b1;
    end else if (fs_fall) begin
      n.in_frame = 1'b1;
      n.cnt = '0;
      n.falls = '0;
      n.is_read = 1'b0;
      n.oe_n = 1'b1;
    end else if (st.in_frame && fs_rise) begin
      n.in_frame = 1'b0;
      n.oe_n = 1'b1;
      n.wr_done = ~st.is_read & (st.cnt == cdhp_pkg::FRAME_BITS);
      n.rd_done = st.is_read & (st.falls == cdhp_pkg::OUT_BITS);
    end else if (st.in_frame) begin
      if (sck_rise && (st.cnt < cdhp_pkg::HDR_BITS || (!st.is_read && st.cnt < cdhp_pkg::FRAME_BITS))) begin
        n.cnt = st.cnt + 5'h01;
        n.in_sh = {st.in_sh[6:0], si};
        if (st.cnt == cdhp_pkg::HDR_RW_POS) begin
          n.is_read = si;
        end
        if (st.cnt == cdhp_pkg::HDR_RS_POS) begin
          n.sel_data = si;
        end
      end
      if (sck_fall && st.is_read && st.cnt == cdhp_pkg::HDR_BITS && st.falls < cdhp_pkg::OUT_BITS) begin
        byte_v = (st.falls == 4'h0) ? ser.rd_byte : st.out_sh;
        n.sio_out = byte_v[7];
        n.out_sh = {byte_v[6:0], 1'b0};
        n.oe_n = 1'b0;
        n.falls = st.falls + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= RST_STATE;
    end else begin
      st <= n;
    end
  end

  assign serial_data_out  = st.sio_out;
  assign serial_data_oe_n = st.oe_n;
  assign ser.wr_done      = st.wr_done;
  assign ser.rd_done      = st.rd_done;
  assign ser.sel_data     = st.sel_data;
  assign ser.wr_byte      = st.in_sh;

  a_ser_discard_open: assert property (@(posedge ref_clk) disable iff (rst)
    (fs_rise && st.cnt != cdhp_pkg::FRAME_BITS) |=> !st.wr_done)
    else $error("serial write committed without a full two byte frame");
  a_ser_write_commit: assert property (@(posedge ref_clk) disable iff (rst)
    (ser_en && st.in_frame && fs_rise && !st.is_read && st.cnt == cdhp_pkg::FRAME_BITS) |=> st.wr_done ##1 !st.wr_done)
    else $error("closed serial write frame not committed as one pulse");
  a_ser_read_msb: assert property (@(posedge ref_clk) disable iff (rst)
    (ser_en && st.in_frame && !fs_rise && !fs_fall && sck_fall && st.is_read && st.cnt == cdhp_pkg::HDR_BITS
     && st.falls == 4'h0) |=> (!serial_data_oe_n && serial_data_out == $past(ser.rd_byte[7])))
    else $error("serial read did not present msb after first falling edge");
endmodule : cdhp_serial_link

/* verification/cdhp_host_model.sv */
module cdhp_host_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] data_lines_out,
  input  wire logic       serial_data_out,
  output logic            register_select_line,
  output logic            rw_line,
  output logic            enable_strobe,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic      [7:0] dl_drv,
  output logic            serial_clk,
  output logic            frame_select,
  output logic            si_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {register_select_line, rw_line, enable_strobe} = 3'h0;
    {write_strobe_n, read_strobe_n, serial_clk, frame_select, si_drv} = 5'h1f;
    dl_drv = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic nib(input logic rd, input logic rs, input logic [7:0] v, output logic [7:0] q);
    @(posedge ref_clk);
    register_select_line <= rs;
    rw_line <= rd;
    dl_drv <= rd ? ~dl_drv : v;
    if (mode == cdhp_pkg::MODE_STROBE) enable_strobe <= 1'b1;
    else if (rd) read_strobe_n <= 1'b0;
    else write_strobe_n <= 1'b0;
    cyc(8);
    q = data_lines_out;
    enable_strobe <= 1'b0;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    cyc(8);
  endtask : nib
  task automatic par(input logic rd, input logic rs, input logic wide, input logic [7:0] b, output logic [7:0] q);
    logic [7:0] h;
    logic [7:0] l;
    if (wide) nib(rd, rs, b, q);
    else begin
      nib(rd, rs, {b[7:4], 4'h5}, h);
      nib(rd, rs, {b[3:0], 4'ha}, l);
      q = {h[7:4], l[7:4]};
    end
  endtask : par
  task automatic ser(input logic rw, input logic rs, input logic [7:0] b, input int nb, output logic [7:0] r);
    logic [15:0] f;
    f = {5'h1f, rw, rs, 1'b0, b};
    r = 8'h00;
    @(posedge ref_clk);
    frame_select <= 1'b0;
    cyc(8);
    for (int i = 15; i >= 16 - nb; i--) begin
      if (i == 7 && rw) cyc(260);
      serial_clk <= 1'b0;
      si_drv <= (i < 8 && rw) ? ~si_drv : f[i];
      cyc(20);
      if (i < 8 && rw) r[i] = serial_data_out;
      serial_clk <= 1'b1;
      cyc(20);
    end
    frame_select <= 1'b1;
    si_drv <= 1'b1;
    cyc(20);
  endtask : ser
endmodule : cdhp_host_model

/* verification/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 0, rst = 1, ext_reset_en = 0, reset_pin_n = 1, wide = 1;
  logic [1:0] mode_sel = 2'h0;
  logic       rs, rw, en, wr_n, rd_n, sck, fs, si_drv, so, so_oe_n, dl_oe_n, bw, gh;
  logic [7:0] dl_drv, dl_out, code, gbits, q;
  logic [6:0] ac;
  logic       disp_row = 0;
  logic [4:0] disp_col = 5'h00;
  logic [2:0] glyph_row = 3'h0;
  int         bad_count = 0, checks = 0;
  wire  [7:0] dl_in = dl_oe_n ? dl_drv : dl_out;
  wire        si = so_oe_n ? si_drv : so;
  cdhp_host_port cdhp_host_port_i (.ref_clk(ref_clk), .rst(rst), .mode_sel(mode_sel),
    .ext_reset_en(ext_reset_en), .reset_pin_n(reset_pin_n), .register_select_line(rs), .rw_line(rw),
    .enable_strobe(en), .write_strobe_n(wr_n), .read_strobe_n(rd_n), .data_lines_in(dl_in),
    .data_lines_out(dl_out), .data_lines_oe_n(dl_oe_n), .serial_clk(sck), .frame_select(fs),
    .serial_data_in(si), .serial_data_out(so), .serial_data_oe_n(so_oe_n), .disp_row(disp_row),
    .disp_col(disp_col), .glyph_row(glyph_row), .disp_code(code), .glyph_bits(gbits), .glyph_hit(gh),
    .address_counter(ac), .bus_width_bit(bw));
  cdhp_host_model cdhp_host_model_i (.ref_clk(ref_clk), .mode(mode_sel), .data_lines_out(dl_in),
    .serial_data_out(si), .register_select_line(rs), .rw_line(rw), .enable_strobe(en),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .dl_drv(dl_drv), .serial_clk(sck),
    .frame_select(fs), .si_drv(si_drv));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    #1;
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input logic rs_v, input logic [7:0] b);
    cdhp_host_model_i.par(1'b0, rs_v, wide, b, q);
  endtask : w
  task automatic r(input logic [7:0] exp);
    cdhp_host_model_i.par(1'b1, 1'b1, wide, 8'h00, q);
    chk(q, exp);
  endtask : r
  task automatic show(input logic row, input logic [4:0] col, input logic [2:0] gr);
    @(posedge ref_clk);
    disp_row <= row;
    disp_col <= col;
    glyph_row <= gr;
    repeat (3) @(posedge ref_clk);
  endtask : show
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    #200us;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk({1'b0, ac}, 8'h00);
    chk({7'h00, bw}, 8'h01);
    w(0, 8'ha7); w(1, 8'h55); chk({1'b0, ac}, 8'h40);
    w(0, 8'he7); w(1, 8'h66); chk({1'b0, ac}, 8'h00);
    w(0, 8'ha7); r(8'h55);
    w(0, 8'hb0); w(1, 8'h77); w(0, 8'hb0); r(8'h00);
    w(0, 8'h04); w(0, 8'hc0); w(1, 8'h0a); chk({1'b0, ac}, 8'h27);
    w(0, 8'h80); w(1, 8'h02); chk({1'b0, ac}, 8'h67);
    w(0, 8'h40); w(1, 8'hf0); chk({1'b0, ac}, 8'h3f);
    w(0, 8'h06); w(0, 8'h7f); w(1, 8'h1f); chk({1'b0, ac}, 8'h00);
    w(0, 8'h53); w(1, 8'h0e);
    cdhp_host_model_i.par(1'b1, 1'b0, wide, 8'h00, q); chk(q, 8'h14);
    $display("test counter done");
    show(0, 5'h00, 3'h3); chk(code, 8'h02); chk(gbits, 8'h0e); chk({7'h00, gh}, 8'h01);
    show(1, 5'h00, 3'h3); chk(code, 8'h0a); chk(gbits, 8'h0e);
    w(0, 8'h1c); show(1, 5'h00, 3'h3); chk(code, 8'h66); chk({7'h00, gh}, 8'h00);
    w(0, 8'h18); show(0, 5'h00, 3'h3); chk(code, 8'h02);
    w(0, 8'h1c); show(0, 5'h00, 3'h3); chk(code, 8'h55);
    show(0, 5'h01, 3'h3); chk(code, 8'h02);
    w(0, 8'h02); chk({1'b0, ac}, 8'h00); show(0, 5'h00, 3'h3); chk(code, 8'h02);
    w(0, 8'h07); w(0, 8'h81); w(1, 8'h44); show(0, 5'h00, 3'h3); chk(code, 8'h44);
    w(0, 8'h01); w(0, 8'h06); chk({1'b0, ac}, 8'h00); show(0, 5'h00, 3'h3); chk(code, 8'h02);
    $display("test display done");
    @(posedge ref_clk); mode_sel <= cdhp_pkg::MODE_RDWR;
    w(0, 8'ha0); w(1, 8'h3c); w(0, 8'ha0); r(8'h3c);
    w(0, 8'h20); chk({7'h00, bw}, 8'h00);
    wide = 0;
    w(0, 8'ha1); w(1, 8'hc3); w(0, 8'ha1); r(8'hc3);
    w(0, 8'h30); wide = 1; chk({7'h00, bw}, 8'h01);
    $display("test parallel done");
    @(posedge ref_clk); mode_sel <= cdhp_pkg::MODE_SERIAL;
    cdhp_host_model_i.ser(0, 0, 8'ha5, 16, q); cdhp_host_model_i.ser(0, 1, 8'h99, 16, q);
    chk({1'b0, ac}, 8'h26);
    cdhp_host_model_i.ser(0, 1, 8'h11, 12, q); chk({1'b0, ac}, 8'h26);
    cdhp_host_model_i.ser(0, 0, 8'ha5, 16, q); cdhp_host_model_i.ser(1, 1, 8'h00, 16, q);
    chk(q, 8'h99); chk({1'b0, ac}, 8'h26);
    $display("test serial done");
    @(posedge ref_clk); mode_sel <= cdhp_pkg::MODE_STROBE;
    ext_reset_en <= 1'b1; reset_pin_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk({1'b0, ac}, 8'h00);
    @(posedge ref_clk); reset_pin_n <= 1'b1;
    $display("test reset done");
    conclude();
  end
endmodule : tb
